// ===== dcb_defs.svh
// Offsets, field positions, reset values and timing counts of the clock gating block
`ifndef DCB_DEFS_SVH
`define DCB_DEFS_SVH

`define DCB_NUM_OUT        12
`define DCB_CTRL_OFFSET    32'h0000_0000
`define DCB_STATUS_OFFSET  32'h0000_0004
`define DCB_CTRL_RESET     12'hFFF
`define DCB_STAT_LOCK_BIT  12
`define DCB_STAT_PD_BIT    13
`define DCB_CLK_MHZ        100
`define DCB_STAB_TIME_US   1500
`define DCB_STAB_LIMIT_US  1800
`define DCB_GATE_DELAY     3'd4
`define DCB_PD_SAMPLES     2'd2

`endif

// ===== dcb_pkg.sv
// Types shared by the clock gating block
package dcb_pkg;

    typedef struct packed {
        logic [11:0] p;
        logic [11:0] n;
    } dcb_diff_t;

    typedef struct packed {
        logic p;
        logic n;
    } dcb_leg_t;

    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_STAB,
        PWR_RUN
    } dcb_pwr_t;

endpackage

// ===== dcb_gate.sv
// Output gating, power-down and power-up sequencing for the twelve-output clock buffer
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
`include "dcb_defs.svh"

module dcb_gate
    import dcb_pkg::*;
#(
    parameter int STAB_CYCLES = `DCB_STAB_TIME_US * `DCB_CLK_MHZ
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Device pins
    input  wire logic        power_good_down_n,
    input  wire logic        ref_clock_valid,
    input  wire logic [11:0] out_enable_n,
    // Clock outputs and PLL state
    output dcb_diff_t        diff_clock_out,
    output dcb_leg_t         feedback_clock_out,
    output logic             pll_on
);

    logic [11:0] ctrl_reg;
    logic [11:0] oe_meta_reg;
    logic [11:0] oe_sync_reg;
    logic [11:0] gate_reg;
    logic [11:0] gate_next;
    logic [11:0] req;
    logic [2:0]  cnt_reg [12];
    logic [1:0]  pd_cnt_reg;
    logic [17:0] stab_cnt_reg;
    logic        phase_reg;
    logic [31:0] prdata_reg;
    dcb_pwr_t    state_reg;
    dcb_diff_t   diff_reg;
    dcb_leg_t    fb_reg;
    logic        run;
    logic        rise_en;
    logic        fall_en;
    logic        pd_stop;
    logic        setup;
    logic        hit;

    function automatic logic addr_hit(input logic [31:0] a);
        addr_hit = (a == `DCB_CTRL_OFFSET) || (a == `DCB_STATUS_OFFSET);
    endfunction

    // Zero-wait slave; read data is latched in the setup cycle
    assign setup   = psel & ~penable;
    assign hit     = addr_hit(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata  = prdata_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= `DCB_CTRL_RESET;
        else if (psel && penable && pwrite && paddr == `DCB_CTRL_OFFSET)
            ctrl_reg <= pwdata[11:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0000_0000;
        else if (setup && !pwrite)
        begin
            prdata_reg <= 32'h0000_0000;
            if (paddr == `DCB_CTRL_OFFSET)
                prdata_reg[11:0] <= ctrl_reg;
            else if (paddr == `DCB_STATUS_OFFSET)
            begin
                prdata_reg[11:0]                <= gate_reg;
                prdata_reg[`DCB_STAT_LOCK_BIT]  <= run;
                prdata_reg[`DCB_STAT_PD_BIT]    <= ~pll_on;
            end
        end
    end

    // Pins change with no relation to pclk; only the second stage is used
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oe_meta_reg <= 12'hFFF;
            oe_sync_reg <= 12'hFFF;
        end
        else
        begin
            oe_meta_reg <= out_enable_n;
            oe_sync_reg <= oe_meta_reg;
        end
    end

    // Output clock is pclk divided by two
    assign run     = (state_reg == PWR_RUN);
    assign rise_en = run & ~phase_reg;
    assign fall_en = run & phase_reg;
    assign pd_stop = fall_en && pd_cnt_reg == `DCB_PD_SAMPLES;
    assign pll_on  = (state_reg != PWR_OFF);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            phase_reg <= 1'b0;
        else if (run && !pd_stop)
            phase_reg <= ~phase_reg;
        else
            phase_reg <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pd_cnt_reg <= 2'd0;
        else if (!run)
            pd_cnt_reg <= 2'd0;
        else if (rise_en)
        begin
            if (power_good_down_n)
                pd_cnt_reg <= 2'd0;
            else if (pd_cnt_reg != `DCB_PD_SAMPLES)
                pd_cnt_reg <= pd_cnt_reg + 2'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg    <= PWR_OFF;
            stab_cnt_reg <= 18'd0;
        end
        else
        begin
            case (state_reg)
                PWR_OFF:
                begin
                    stab_cnt_reg <= 18'd0;
                    if (power_good_down_n && ref_clock_valid)
                        state_reg <= PWR_STAB;
                end
                PWR_STAB:
                begin
                    if (!power_good_down_n || !ref_clock_valid)
                        state_reg <= PWR_OFF;
                    else if (stab_cnt_reg == 18'(STAB_CYCLES - 1))
                        state_reg <= PWR_RUN;
                    else
                        stab_cnt_reg <= stab_cnt_reg + 18'd1;
                end
                PWR_RUN:
                begin
                    if (pd_stop)
                        state_reg <= PWR_OFF;
                end
                default:
                    state_reg <= PWR_OFF;
            endcase
        end
    end

    assign req = ctrl_reg & ~oe_sync_reg;

    // Count rising output edges while request and gate disagree, act on a falling edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 12; i++)
                cnt_reg[i] <= 3'd0;
        end
        else
        begin
            for (int i = 0; i < 12; i++)
            begin
                if (!run || req[i] == gate_reg[i] || fall_en && cnt_reg[i] == `DCB_GATE_DELAY)
                    cnt_reg[i] <= 3'd0;
                else if (rise_en && cnt_reg[i] != `DCB_GATE_DELAY)
                    cnt_reg[i] <= cnt_reg[i] + 3'd1;
            end
        end
    end

    always_comb
    begin
        gate_next = gate_reg;
        for (int i = 0; i < 12; i++)
            if (fall_en && req[i] != gate_reg[i] && cnt_reg[i] == `DCB_GATE_DELAY)
                gate_next[i] = req[i];
        if (pd_stop || !run)
            gate_next = 12'h000;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gate_reg <= 12'h000;
        else
            gate_reg <= gate_next;
    end

    // Legs come from flip-flops so no gate output ever glitches
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            diff_reg <= '0;
            fb_reg   <= '0;
        end
        else
        begin
            diff_reg.p <= {12{run & ~phase_reg & ~pd_stop}} & gate_next;
            diff_reg.n <= {12{run & phase_reg & ~pd_stop}} & gate_next;
            fb_reg.p   <= run & ~phase_reg & ~pd_stop;
            fb_reg.n   <= run & phase_reg & ~pd_stop;
        end
    end

    assign diff_clock_out     = diff_reg;
    assign feedback_clock_out = fb_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    gate_rise_cause_a: assert property (
        gate_reg[0] && !$past(gate_reg[0]) |-> $past(ctrl_reg[0] && !oe_sync_reg[0]))
        else $error("Output 0 enabled without bit set and pin low");

    gate_delay_a: assert property (
        $rose(gate_reg[0]) |-> $past(cnt_reg[0]) == `DCB_GATE_DELAY)
        else $error("Output 0 enabled before four output periods");

    gate_while_low_a: assert property (
        gate_reg != $past(gate_reg) |-> !phase_reg)
        else $error("Gate changed while output clock high");

    disabled_low_a: assert property (
        ((diff_clock_out.p | diff_clock_out.n) & ~gate_reg) == 12'h000)
        else $error("Disabled output leg not low");

    off_all_low_a: assert property (
        state_reg == PWR_OFF |-> diff_clock_out == '0 && feedback_clock_out == '0 && !pll_on)
        else $error("Outputs or PLL active while powered down");

    pd_stop_low_a: assert property (
        pd_cnt_reg == `DCB_PD_SAMPLES && fall_en
            |=> diff_clock_out == '0 && feedback_clock_out == '0 && !pll_on)
        else $error("Outputs not stopped after two low samples");

    fb_running_a: assert property (
        run && pd_cnt_reg == 2'd0 ##1 run |-> fb_reg.p != $past(fb_reg.p))
        else $error("Feedback clock stalled while running");

    stab_count_a: assert property (
        run && $past(state_reg) == PWR_STAB |-> $past(stab_cnt_reg) == 18'(STAB_CYCLES - 1))
        else $error("Outputs started before stabilization interval");

endmodule

// ===== dcb_ref_src.sv
// Upstream reference source model for the clock gating bench
`timescale 1ns/1ns
module dcb_ref_src
(
    // Clock and request
    input  wire logic pclk,
    input  wire logic start,
    // Reference status
    output logic      ref_clock_valid
);
    logic [2:0] lock_reg;

    // The synthesizer needs a few cycles to settle before its clock counts as valid
    always_ff @(posedge pclk)
    begin
        lock_reg        <= start ? lock_reg + (lock_reg != 3'h7) : 3'h0;
        ref_clock_valid <= start && (lock_reg == 3'h7);
    end
endmodule

// ===== tb_top.sv
// Self-checking bench for the clock gating block
`timescale 1ns/1ns
module tb_top
    import dcb_pkg::*;
;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pgd;
    logic        start;
    logic        rv;
    logic [11:0] oen;
    dcb_diff_t   dout;
    dcb_leg_t    fb;
    logic        pll_on;
    logic        err;
    logic [31:0] d;
    logic [11:0] r;
    logic        f;
    logic        prev;
    logic        fn;
    int          last;
    int          n_mismatch;
    int          num_checks;
    int          i;
    int          k;

    dcb_ref_src src (.pclk(pclk), .start(start), .ref_clock_valid(rv));

    dcb_gate #(.STAB_CYCLES(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .power_good_down_n(pgd), .ref_clock_valid(rv),
        .out_enable_n(oen), .diff_clock_out(dout), .feedback_clock_out(fb), .pll_on(pll_on));

    initial
    begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end

    task test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask

    // Entered just after a rising edge; holds the request until pready is seen
    task apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        int j;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        for (j = 0; j < 20 && pready !== 1'b1; j++)
            @(posedge pclk);
        if (j == 20)
        begin
            n_mismatch++;
            test_done();
        end
        d = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        // Idle edge so a following call never reassigns psel in the same step
        @(posedge pclk);
    endtask

    task watch(input int n);
        r = 0;
        f = 0;
        fn = 0;
        repeat (n)
        begin
            @(posedge pclk);
            r = r | dout.p | dout.n;
            f = f | fb.p;
            fn = fn | fb.n;
        end
    endtask

    initial
    begin
        {presetn, psel, penable, pwrite, start, pgd} = 0;
        paddr = 0;
        pwdata = 0;
        oen = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, 32'h0000_0000, 0);
        chk("ctrl", 32'h0000_0FFF, d);
        apb(0, 32'h0000_0008, 0);
        chk("bad_data", 32'h0000_0000, d);
        chk("bad_err", 32'h0000_0001, 32'(err));
        pgd <= 1;
        start <= 1;
        for (i = 0; i < 100 && d[12] !== 1'b1; i++)
            apb(0, 32'h0000_0004, 0);
        chk("lock", 1, 32'(d[12]));
        chk("pll", 1, 32'(pll_on));
        watch(40);
        chk("all", 32'h0000_0FFF, 32'(r));
        apb(1, 32'h0000_0000, 32'h0000_0FF7);
        oen[5] <= 1;
        k = 0;
        last = 0;
        prev = dout.p[5];
        for (i = 0; i < 30; i++)
        begin
            @(posedge pclk);
            if (dout.p[5] && !prev)
            begin
                k++;
                last = i;
            end
            prev = dout.p[5];
        end
        chk("drain", 1, 32'(k >= 4 && k <= 12));
        chk("stop", 1, 32'(last < 24));
        watch(20);
        chk("gated", 32'h0000_0FD7, 32'(r));
        chk("fb", 32'h0000_0003, 32'({f, fn}));
        oen[5] <= 0;
        for (i = 0; i < 40 && dout.p[5] !== 1'b1; i++)
            @(posedge pclk);
        chk("resume", 1, 32'(i >= 8 && i <= 24));
        apb(0, 32'h0000_0004, 0);
        chk("gates", 32'h0000_0FF7, 32'(d[11:0]));
        pgd <= 0;
        @(posedge pclk);
        pgd <= 1;
        watch(10);
        chk("blip", 32'h0000_0FF7, 32'(r));
        pgd <= 0;
        repeat (8) @(posedge pclk);
        watch(10);
        chk("down", 0, 32'({r, f, fn, pll_on}));
        test_done();
    end
endmodule
